// ==== include/amc_map.vh ====
// register layout and timing constants for the mode-control word decoder
`ifndef AMC_MAP_VH
`define AMC_MAP_VH
`define AMC_WORD_BITS 16
`define AMC_REG_SEL_BIT 15
`define AMC_SCAN_HI 14
`define AMC_SCAN_LO 11
`define AMC_CHAN_HI 10
`define AMC_CHAN_LO 7
`define AMC_RST_HI 6
`define AMC_RST_LO 5
`define AMC_PM_HI 4
`define AMC_PM_LO 3
`define AMC_TAG_BIT 2
`define AMC_SOFT_CONVERT_TRIGGER_BIT 1
`define AMC_SCAN_RESET 4'h1
`define AMC_CHAN_RESET 4'h0
`define AMC_PM_RESET 2'h0
`define AMC_SCAN_KEEP 4'h0
`define AMC_SCAN_MANUAL 4'h1
`define AMC_SCAN_REPEAT 4'h2
`define AMC_SCAN_STD_INT 4'h3
`define AMC_RESULT_BITS 12
`define AMC_TAG_BITS 4
`define AMC_CONV_TIME_NS 2000
`define AMC_CLK_NS 10
`define AMC_CONV_CYCLES ((`AMC_CONV_TIME_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
`endif

// ==== src/amc_decode.v ====
// mode-control word decoder: serial capture, field decode, scan sequencing
`timescale 1ns/100ps
`default_nettype none
`include "amc_map.vh"

// Notes on behaviour
// [R1] word with top bit zero writes mode control; top bit one goes elsewhere
// [R2] scan code in bits 14:11, channel number N in bits 10:7
// [R3] external clock: power-management field bits 4:3 selects power mode, resets zero
// [R4] external clock, tag bit set: output 4-bit channel then 12-bit result MSB first
// [R5] internal clock: channel number always present in output word
// [R6] internal clock: soft-convert bit starts conversion on chip-select rising edge
// [R7] host rewrites soft-convert bit for each further soft conversion
// [R8] scan code zero keeps previous scan mode and ignores bits 10:0 for scanning
// [R9] scan code zero still accepts bits 6:3 and bit 1
// [R10] manual: host names next channel each frame; result returned next frame
// [R11] manual runs on external clock only, one channel per frame, no averaging
// [R12] repeat converts channel N per frame, stores 4, 8, 12 or 16 results; code converts N repeat_target times per start
// [R13] standard internal converts channels 0 through N ascending with internal clock
// [R14] standard internal scan leaves one stored result per channel
// [R15] bit 0 has no function and is treated as zero
module amc_decode #(
  parameter CONV_CYCLES = `AMC_CONV_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire cs_n_pin,
  input wire sclk_pin,
  input wire din_pin,
  input wire convert_start_pin_n,
  input wire [1:0] repeat_count_sel,
  input wire [11:0] conv_result,
  output reg dout,
  output reg [3:0] scan_mode_q,
  output reg [3:0] channel_number_field_q,
  output reg [1:0] power_mgmt_sel_q,
  output reg channel_tag_enable_q,
  output reg soft_convert_trigger_q,
  output reg [1:0] reset_request_q,
  output reg cfg_word_valid_q,
  output reg [15:0] cfg_word_q,
  output reg internal_clock_mode_q,
  output reg conv_busy_q,
  output reg [3:0] conv_channel_q,
  output reg conv_done_q,
  output reg [4:0] fifo_count_q
);
  // two-flop synchronisers; of the first two stages only the second feeds logic
  // third stage of cs, sclk and cnv only feeds the edge detectors
  reg [2:0] cs_s, sclk_s, cnv_s;
  reg [1:0] din_s;
  always @(posedge clk) begin
    if (rst) begin
      cs_s <= 3'h7;
      sclk_s <= 3'h0;
      din_s <= 2'h0;
      cnv_s <= 3'h7;
    end else begin
      cs_s <= {cs_s[1:0], cs_n_pin};
      sclk_s <= {sclk_s[1:0], sclk_pin};
      din_s <= {din_s[0], din_pin};
      cnv_s <= {cnv_s[1:0], convert_start_pin_n};
    end
  end
  wire cs_n = cs_s[1];
  wire cs_fall = cs_s[2] & ~cs_s[1];
  wire cs_rise = ~cs_s[2] & cs_s[1];
  wire sclk_rise = ~sclk_s[2] & sclk_s[1];
  wire sclk_fall = sclk_s[2] & ~sclk_s[1];
  wire cnv_fall = cnv_s[2] & ~cnv_s[1];

  // serial capture, MSB first on rising sclk
  reg [15:0] shift_q;
  reg [4:0] bit_cnt_q;
  reg [15:0] out_sh_q;
  reg [11:0] held_result_q;
  reg [3:0] held_chan_q;
  wire [15:0] w = {shift_q[14:0], din_s[1]};
  wire [3:0] new_scan = shift_q[`AMC_SCAN_HI:`AMC_SCAN_LO];
  wire keep = (new_scan == `AMC_SCAN_KEEP);
  // mode in force after this word; a keep code leaves the stored one
  wire [3:0] next_scan = keep ? scan_mode_q : new_scan;
  // manual result carries the channel named in the frame just ended, or the stored channel after a keep code
  wire [3:0] manual_chan = keep ? channel_number_field_q
                                : shift_q[`AMC_CHAN_HI:`AMC_CHAN_LO]; // [R10]
  // counter stops one past a full word so longer frames are refused
  localparam [4:0] FRAME_BITS = 5'd`AMC_WORD_BITS;
  localparam [4:0] OVER_BITS = FRAME_BITS + 5'h01;
  wire tag_out = internal_clock_mode_q | channel_tag_enable_q; // [R4] [R5]
  wire [15:0] frame_word = tag_out ? {held_chan_q, held_result_q} // [R4]
                                   : {held_result_q, 4'h0};

  always @(posedge clk) begin
    if (rst) begin
      shift_q <= 16'h0000;
      bit_cnt_q <= 5'h00;
      out_sh_q <= 16'h0000;
      dout <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_q <= 5'h00;
      out_sh_q <= frame_word;
      dout <= frame_word[15];
    end else if (!cs_n) begin
      if (sclk_rise && bit_cnt_q != OVER_BITS) begin
        if (bit_cnt_q != FRAME_BITS) begin
          shift_q <= w;
        end
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (sclk_fall) begin
        out_sh_q <= {out_sh_q[14:0], 1'b0};
        dout <= out_sh_q[14];
      end
    end
  end

  // decode of a complete 16-bit word, applied at chip-select rise
  wire word_done = cs_rise && bit_cnt_q == FRAME_BITS;
  always @(posedge clk) begin
    if (rst) begin
      scan_mode_q <= `AMC_SCAN_RESET;
      channel_number_field_q <= `AMC_CHAN_RESET;
      power_mgmt_sel_q <= `AMC_PM_RESET; // [R3]
      channel_tag_enable_q <= 1'b0;
      soft_convert_trigger_q <= 1'b0;
      reset_request_q <= 2'h0;
      cfg_word_valid_q <= 1'b0;
      cfg_word_q <= 16'h0000;
      internal_clock_mode_q <= 1'b0;
    end else begin
      cfg_word_valid_q <= 1'b0;
      reset_request_q <= 2'h0;
      soft_convert_trigger_q <= 1'b0; // [R7] one-shot, host must rewrite
      if (word_done) begin
        if (shift_q[`AMC_REG_SEL_BIT]) begin // [R1]
          cfg_word_valid_q <= 1'b1;
          cfg_word_q <= shift_q;
        end else begin
          // bits 6:3 always land, bit 1 unless the next mode is manual; bit 0 is dropped
          reset_request_q <= shift_q[`AMC_RST_HI:`AMC_RST_LO]; // [R9]
          power_mgmt_sel_q <= shift_q[`AMC_PM_HI:`AMC_PM_LO]; // [R3] [R9]
          // soft start only exists with the internal clock, so manual drops it
          soft_convert_trigger_q <= shift_q[`AMC_SOFT_CONVERT_TRIGGER_BIT] &&
                                    (next_scan != `AMC_SCAN_MANUAL); // [R6] [R15]
          if (!keep) begin // [R8]
            // tag bit is not among the fields a keep word may still write
            channel_tag_enable_q <= shift_q[`AMC_TAG_BIT]; // [R4] [R9]
            scan_mode_q <= new_scan; // [R2]
            channel_number_field_q <= shift_q[`AMC_CHAN_HI:`AMC_CHAN_LO]; // [R2]
            internal_clock_mode_q <= (new_scan != `AMC_SCAN_MANUAL); // [R11]
          end
        end
      end
    end
  end

  // conversion sequencer
  reg [15:0] timer_q;
  reg [3:0] last_chan_q;
  wire [4:0] repeat_target = {repeat_count_sel, 2'b00} + 5'h04; // [R12]
  wire int_mode = (scan_mode_q == `AMC_SCAN_REPEAT) || (scan_mode_q == `AMC_SCAN_STD_INT);
  // soft trigger is honoured only when the internal clock runs the scan
  wire start = !conv_busy_q && int_mode &&
               ((soft_convert_trigger_q && cs_n) || cnv_fall); // [R6]
  wire manual_frame = word_done && !shift_q[`AMC_REG_SEL_BIT] &&
                      (scan_mode_q == `AMC_SCAN_MANUAL);
  always @(posedge clk) begin
    if (rst) begin
      conv_busy_q <= 1'b0;
      conv_channel_q <= 4'h0;
      conv_done_q <= 1'b0;
      fifo_count_q <= 5'h00;
      timer_q <= 16'h0000;
      last_chan_q <= 4'h0;
      held_result_q <= 12'h000;
      held_chan_q <= 4'h0;
    end else begin
      conv_done_q <= 1'b0;
      // both reset codes empty the store; a later increment in this cycle wins
      if (reset_request_q == 2'h1 || reset_request_q == 2'h2)
        fifo_count_q <= 5'h00;
      if (manual_frame) begin
        // single conversion, no averaging; result leaves in next frame
        held_result_q <= conv_result; // [R10] [R11]
        held_chan_q <= manual_chan;
        conv_done_q <= 1'b1;
      end else if (start) begin
        conv_busy_q <= 1'b1;
        fifo_count_q <= 5'h00;
        timer_q <= 16'h0000;
        if (scan_mode_q == `AMC_SCAN_STD_INT) begin
          conv_channel_q <= 4'h0; // [R13]
          last_chan_q <= channel_number_field_q;
        end else begin
          conv_channel_q <= channel_number_field_q; // [R12]
          last_chan_q <= channel_number_field_q;
        end
      end else if (conv_busy_q) begin
        if (timer_q == CONV_CYCLES[15:0] - 16'h0001) begin
          timer_q <= 16'h0000;
          held_result_q <= conv_result;
          held_chan_q <= conv_channel_q;
          fifo_count_q <= fifo_count_q + 5'h01; // [R14]
          if (scan_mode_q == `AMC_SCAN_STD_INT) begin
            if (conv_channel_q == last_chan_q) begin
              conv_busy_q <= 1'b0;
              conv_done_q <= 1'b1;
            end else begin
              conv_channel_q <= conv_channel_q + 4'h1; // [R13]
            end
          end else if (fifo_count_q + 5'h01 == repeat_target) begin // [R12]
            conv_busy_q <= 1'b0;
            conv_done_q <= 1'b1;
          end
        end else begin
          timer_q <= timer_q + 16'h0001;
        end
      end
    end
  end
endmodule // amc_decode
`default_nettype wire

// ==== test/amc_decode_chk.sv ====
// assertion checker for the mode-control word decoder
`timescale 1ns/100ps
`default_nettype none
module amc_decode_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic [3:0] scan_mode_q,
  input wire logic [3:0] channel_number_field_q,
  input wire logic [1:0] power_mgmt_sel_q,
  input wire logic soft_convert_trigger_q,
  input wire logic cfg_word_valid_q,
  input wire logic [15:0] cfg_word_q,
  input wire logic internal_clock_mode_q,
  input wire logic conv_busy_q,
  input wire logic [3:0] conv_channel_q,
  input wire logic [4:0] fifo_count_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_one_shot; soft_convert_trigger_q ##1 !soft_convert_trigger_q; endsequence
  // reset itself must be watched, so this one is never disabled
  property p_rst_vals; disable iff (1'b0) rst |=> {scan_mode_q, power_mgmt_sel_q} == 6'h04;
  endproperty
  property p_mode_cs; !$stable(scan_mode_q) |-> cs_n_pin; endproperty
  property p_keep_code; scan_mode_q != 4'h0; endproperty
  property p_sw_pulse; soft_convert_trigger_q |-> s_one_shot; endproperty
  property p_sw_int; soft_convert_trigger_q |-> scan_mode_q != 4'h1; endproperty
  property p_int_mode; $stable(scan_mode_q) |-> internal_clock_mode_q == (scan_mode_q != 4'h1);
  endproperty
  property p_chan_bound; conv_busy_q |-> conv_channel_q <= channel_number_field_q; endproperty
  property p_chan_step; conv_busy_q && $past(conv_busy_q) && $changed(conv_channel_q)
    |-> conv_channel_q == $past(conv_channel_q) + 4'h1; endproperty
  property p_fifo_cap; fifo_count_q <= 5'h10; endproperty
  property p_cfg_top; cfg_word_valid_q |-> cfg_word_q[15] ##1 !cfg_word_valid_q; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  a_mode_cs: assert property (p_mode_cs) else $error("mode changed in frame");
  a_keep_code: assert property (p_keep_code) else $error("keep code stored");
  a_sw_pulse: assert property (p_sw_pulse) else $error("soft trigger too long");
  a_sw_int: assert property (p_sw_int) else $error("soft trigger in manual");
  a_int_mode: assert property (p_int_mode) else $error("clock mode wrong");
  a_chan_bound: assert property (p_chan_bound) else $error("channel above N");
  a_chan_step: assert property (p_chan_step) else $error("channel order wrong");
  a_fifo_cap: assert property (p_fifo_cap) else $error("fifo count above 16");
  a_cfg_top: assert property (p_cfg_top) else $error("config word wrong");
endmodule // amc_decode_chk
bind amc_decode amc_decode_chk chk_u (.clk(clk), .rst(rst), .cs_n_pin(cs_n_pin),
  .scan_mode_q(scan_mode_q), .channel_number_field_q(channel_number_field_q),
  .power_mgmt_sel_q(power_mgmt_sel_q), .soft_convert_trigger_q(soft_convert_trigger_q),
  .cfg_word_valid_q(cfg_word_valid_q), .cfg_word_q(cfg_word_q),
  .internal_clock_mode_q(internal_clock_mode_q), .conv_busy_q(conv_busy_q),
  .conv_channel_q(conv_channel_q), .fifo_count_q(fifo_count_q));
`default_nettype wire

// ==== test/amc_host.sv ====
// serial host model sending mode-control frames
`timescale 1ns/100ps
`default_nettype none
module amc_host (
  output var logic cs_n,
  output var logic sclk,
  output var logic din,
  input wire logic dout,
  output var logic [15:0] rd_q
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    rd_q = 16'h0000;
  end
  task automatic send(input logic [15:0] w);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din = w[i];
      #62.5 sclk = 1'b1;
      rd_q = {rd_q[14:0], dout};
      #62.5 sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    // released line must not look like held data
    din = ~din;
    #100;
  endtask
endmodule // amc_host
`default_nettype wire

// ==== test/test_amc_decode.sv ====
// self-checking bench for the mode-control word decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module test_amc_decode;
  logic clk, rst, cs_n, sclk, din, cnv_n, dout, tag, sw, cfgv, busy, done, imode;
  logic [1:0] pm, rreq, rsel;
  logic [3:0] scan, chn, cch;
  logic [11:0] res;
  logic [15:0] cfgw, rd;
  logic [4:0] cnt;
  int n_fail = 0;
  int cmp_count = 0;
  int cfg_n = 0;
  int done_n = 0;
  amc_host host_u (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .rd_q(rd));
  amc_decode #(.CONV_CYCLES(4)) dut_u (.clk(clk), .rst(rst), .cs_n_pin(cs_n),
    .sclk_pin(sclk), .din_pin(din), .convert_start_pin_n(cnv_n), .repeat_count_sel(rsel),
    .conv_result(res), .dout(dout), .scan_mode_q(scan), .channel_number_field_q(chn),
    .power_mgmt_sel_q(pm), .channel_tag_enable_q(tag), .soft_convert_trigger_q(sw),
    .reset_request_q(rreq), .cfg_word_valid_q(cfgv), .cfg_word_q(cfgw),
    .internal_clock_mode_q(imode), .conv_busy_q(busy), .conv_channel_q(cch),
    .conv_done_q(done), .fifo_count_q(cnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cfgv === 1'b1) cfg_n++;
    if (done === 1'b1) done_n++;
  end
  task automatic wr(input logic [15:0] w);
    @(posedge clk) #1;
    host_u.send(w);
  endtask
  task automatic wait_done(input int k);
    for (int i = 0; i < 200 && done_n < k; i++) @(posedge clk);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    cnv_n = 1'b1;
    rsel = 2'h2;
    res = 12'hA5C;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("reset", {4'h1, 4'h0, 2'h0, 1'b0}, {scan, chn, pm, tag})
    wr({1'b0, 4'h1, 4'h5, 2'h0, 2'h2, 1'b1, 1'b1, 1'b1});
    `CHK("manual", {4'h1, 4'h5, 2'h2, 2'h2}, {scan, chn, pm, tag, imode})
    wr({1'b0, 4'h1, 4'h9, 7'h04});
    wr({1'b0, 4'h1, 4'h5, 7'h04});
    `CHK("tagged", {4'h9, 12'hA5C}, rd)
    wr({1'b0, 4'h0, 4'hA, 2'h0, 2'h1, 3'h0});
    `CHK("keep", {4'h1, 4'h5, 2'h1, 1'b1}, {scan, chn, pm, tag})
    wr(16'h8123);
    `CHK("cfg", {32'd1, 16'h8123, 4'h1}, {cfg_n, cfgw, scan})
    wr({1'b0, 4'h2, 4'h3, 7'h00});
    `CHK("repeat", {4'h2, 4'h3, 1'b1}, {scan, chn, imode})
    `CHK("frames", {32'd5, 5'h00}, {done_n, cnt})
    @(posedge clk) #1 cnv_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 cnv_n = 1'b1;
    wait_done(6);
    `CHK("rep_run", {32'd6, 5'h0C}, {done_n, cnt})
    wr({1'b0, 4'h3, 4'h3, 7'h02});
    wait_done(7);
    `CHK("scan", {32'd7, 5'h04}, {done_n, cnt})
    wr({1'b0, 4'h0, 4'h0, 7'h02});
    wait_done(8);
    `CHK("again", {32'd8, 5'h04, 4'h3, 12'hA5C}, {done_n, cnt, rd})
    wr({1'b0, 4'h0, 4'h0, 2'h1, 5'h00});
    `CHK("fifo_rst", 5'h00, cnt)
    final_report;
  end
endmodule // test_amc_decode
`default_nettype wire
